/* core/fac_audio_clock_gen.sv */
// Field-locked audio clock generator: byte register file, phase-accumulator
// master clock with field lock loop, and bit and channel clock dividers.
// Assumes a byte register port fed by the serial control interface, one cycle
// write and read strobes, and a vertical pulse from the decoder on ref_clk.
`timescale 1ns/1ps
// Summary of operation
// (R1) 18-bit master cycles per field, three byte registers, LSB first.
// (R2) 22-bit nominal increment, three byte registers, LSB first.
// (R3) 6-bit ratio divides the master clock down to the bit clock.
// (R4) 6-bit ratio divides the bit clock down to the channel clock.
// (R5) Mode bit clear: loop locks master clock to field; set: free-running.
// (R6) Source bit clear: decoder vertical pulse; set: expansion-port vertical input.
// (R7) Channel clock moves on bit clock falling edges, or rising when set.
// (R8) Bit clock moves on master clock falling edges, or rising when set.
// (R9) Locked loop trims increment so programmed cycles fit each field.
// (R10) Unused upper register bits read zero and ignore writes.
module fac_audio_clock_gen #(
   parameter int unsigned ACC_W      = fac_pkg::ACC_W_DEF,     // Accumulator width
   parameter int unsigned LOOP_SHIFT = fac_pkg::LOOP_SHIFT_DEF // Loop gain shift
) (
   input  wire logic       ref_clk,                // 25 MHz reference clock
   input  wire logic       nrst,                   // Synchronous reset, active low
   input  wire logic [7:0] reg_addr,               // Register subaddress
   input  wire logic [7:0] reg_wdata,              // Write data
   input  wire logic       reg_wr,                 // Write strobe, one cycle
   input  wire logic       reg_rd,                 // Read strobe, one cycle
   output logic      [7:0] reg_rdata,              // Read data, valid cycle after strobe
   input  wire logic       vref_internal,          // Decoder vertical pulse, same clock
   input  wire logic       expansion_vertical_ref, // Expansion-port vertical pin
   output logic            audio_master_clock,     // Master clock out
   output logic            audio_bit_clock,        // Serial bit clock out
   output logic            channel_select_clock    // Channel select clock out
);
   localparam int unsigned CPF_W = fac_pkg::CPF_W;
   localparam int unsigned INC_W = fac_pkg::INC_W;
   localparam int unsigned DIV_W = fac_pkg::DIV_W;
   localparam int unsigned ERR_W = CPF_W + 2;
   localparam int unsigned COR_W = INC_W + 2;

   // Implemented-bit mask of a subaddress; zero marks an unmapped one
   function automatic logic [7:0] fac_reg_mask(input logic [7:0] addr);
      case (addr)
         fac_pkg::ADDR_CPF_LOW,
         fac_pkg::ADDR_CPF_MID,
         fac_pkg::ADDR_INC_LOW,
         fac_pkg::ADDR_INC_MID:    fac_reg_mask = fac_pkg::MASK_FULL;
         fac_pkg::ADDR_CPF_HIGH:   fac_reg_mask = fac_pkg::MASK_CPF_HIGH;
         fac_pkg::ADDR_INC_HIGH:   fac_reg_mask = fac_pkg::MASK_INC_HIGH;
         fac_pkg::ADDR_BIT_RATIO,
         fac_pkg::ADDR_CHAN_RATIO: fac_reg_mask = fac_pkg::MASK_RATIO;
         fac_pkg::ADDR_CTRL:       fac_reg_mask = fac_pkg::MASK_CTRL;
         default:                  fac_reg_mask = fac_pkg::MASK_NONE;
      endcase
   endfunction : fac_reg_mask

   logic [CPF_W-1:0]           cycles_per_field;
   logic [INC_W-1:0]           nominal_increment;
   logic [DIV_W-1:0]           bit_clock_divider;
   logic [DIV_W-1:0]           channel_clock_divider;
   logic [fac_pkg::CTRL_W-1:0] audio_clock_control;
   logic [7:0]                 wdata_m;
   logic [7:0]                 next_rdata;

   wire pll_open_mode       = audio_clock_control[fac_pkg::CTRL_PLL_OPEN];
   wire vertical_ref_source = audio_clock_control[fac_pkg::CTRL_VREF_SRC];
   wire channel_clock_phase = audio_clock_control[fac_pkg::CTRL_CHAN_PHASE];
   wire bit_clock_phase     = audio_clock_control[fac_pkg::CTRL_BIT_PHASE];

   assign wdata_m = reg_wdata & fac_reg_mask(reg_addr); // [R10]

   // Register writes
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         cycles_per_field      <= fac_pkg::RST_CPF;
         nominal_increment     <= fac_pkg::RST_INC;
         bit_clock_divider     <= fac_pkg::RST_RATIO;
         channel_clock_divider <= fac_pkg::RST_RATIO;
         audio_clock_control   <= fac_pkg::RST_CTRL;
      end else if (reg_wr) begin
         case (reg_addr)
            fac_pkg::ADDR_CPF_LOW:    cycles_per_field[7:0]   <= wdata_m;      // [R1]
            fac_pkg::ADDR_CPF_MID:    cycles_per_field[15:8]  <= wdata_m;      // [R1]
            fac_pkg::ADDR_CPF_HIGH:   cycles_per_field[17:16] <= wdata_m[1:0]; // [R1] [R10]
            fac_pkg::ADDR_INC_LOW:    nominal_increment[7:0]   <= wdata_m;      // [R2]
            fac_pkg::ADDR_INC_MID:    nominal_increment[15:8]  <= wdata_m;      // [R2]
            fac_pkg::ADDR_INC_HIGH:   nominal_increment[21:16] <= wdata_m[5:0]; // [R2] [R10]
            fac_pkg::ADDR_BIT_RATIO:  bit_clock_divider     <= wdata_m[5:0];   // [R3] [R10]
            fac_pkg::ADDR_CHAN_RATIO: channel_clock_divider <= wdata_m[5:0];   // [R4] [R10]
            fac_pkg::ADDR_CTRL:       audio_clock_control   <= wdata_m[3:0];   // [R10]
            default:                  ;
         endcase
      end
   end

   // Read mux; unmapped subaddresses read zero
   always_comb begin
      case (reg_addr)
         fac_pkg::ADDR_CPF_LOW:    next_rdata = cycles_per_field[7:0];
         fac_pkg::ADDR_CPF_MID:    next_rdata = cycles_per_field[15:8];
         fac_pkg::ADDR_CPF_HIGH:   next_rdata = {6'h00, cycles_per_field[17:16]};
         fac_pkg::ADDR_INC_LOW:    next_rdata = nominal_increment[7:0];
         fac_pkg::ADDR_INC_MID:    next_rdata = nominal_increment[15:8];
         fac_pkg::ADDR_INC_HIGH:   next_rdata = {2'h0, nominal_increment[21:16]};
         fac_pkg::ADDR_BIT_RATIO:  next_rdata = {2'h0, bit_clock_divider};
         fac_pkg::ADDR_CHAN_RATIO: next_rdata = {2'h0, channel_clock_divider};
         fac_pkg::ADDR_CTRL:       next_rdata = {4'h0, audio_clock_control};
         default:                  next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata & fac_reg_mask(reg_addr); // [R10]
      end
   end

   // Pin synchroniser; first stage feeds only the second
   logic [2:0] xvr_sync;
   logic       xvr_level;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         xvr_sync  <= 3'h0;
         xvr_level <= 1'b0;
      end else begin
         xvr_sync <= {xvr_sync[1:0], expansion_vertical_ref};
         if (xvr_sync[1] == xvr_sync[2]) begin
            xvr_level <= xvr_sync[2];
         end
      end
   end

   // Reference selection and rising-edge detection
   logic vref_sel;
   logic vref_prev;
   logic vref_edge;

   assign vref_sel  = vertical_ref_source ? xvr_level : vref_internal; // [R6]
   assign vref_edge = vref_sel & ~vref_prev;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         vref_prev <= 1'b0;
      end else begin
         vref_prev <= vref_sel;
      end
   end

   // Phase accumulator; its top bit is the master clock
   logic [ACC_W-1:0]        acc;
   logic signed [COR_W-1:0] correction;
   logic signed [COR_W-1:0] inc_sum;
   logic [INC_W-1:0]        inc_eff;
   logic                    audio_master_clock_prev;
   logic                    audio_master_clock_rise;
   logic                    audio_master_clock_fall;

   assign inc_sum = $signed({2'b00, nominal_increment}) + correction; // [R9]
   // Clamp keeps the trimmed increment in its legal range
   always_comb begin
      if (inc_sum < 0) begin
         inc_eff = '0;
      end else if (inc_sum[COR_W-1:INC_W] != '0) begin
         inc_eff = '1;
      end else begin
         inc_eff = inc_sum[INC_W-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         acc        <= '0;
         audio_master_clock_prev <= 1'b0;
      end else begin
         acc        <= acc + ACC_W'(inc_eff);
         audio_master_clock_prev <= acc[ACC_W-1];
      end
   end

   assign audio_master_clock = acc[ACC_W-1];
   assign audio_master_clock_rise         = acc[ACC_W-1] & ~audio_master_clock_prev;
   assign audio_master_clock_fall         = ~acc[ACC_W-1] & audio_master_clock_prev;

   // Master cycles counted over one reference interval, saturating
   logic [CPF_W-1:0]        field_count;
   logic signed [ERR_W-1:0] field_err;

   assign field_err = $signed({2'b00, cycles_per_field}) - $signed({2'b00, field_count});

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         field_count <= '0;
      end else if (vref_edge) begin
         field_count <= audio_master_clock_rise ? CPF_W'(1) : '0;
      end else if (audio_master_clock_rise && field_count != '1) begin
         field_count <= field_count + CPF_W'(1);
      end
   end

   // Lock loop; the shift trades capture speed for jitter
   logic signed [COR_W-1:0] err_step;
   logic signed [COR_W-1:0] next_correction;

   assign err_step        = COR_W'(field_err >>> LOOP_SHIFT);
   assign next_correction = correction + err_step;

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         correction <= '0;
      end else if (pll_open_mode) begin
         correction <= '0;                                        // [R5]
      end else if (vref_edge) begin
         correction <= (err_step == '0 && field_err != '0)
                       ? correction + COR_W'(field_err > 0 ? 1 : -1)
                       : next_correction;                         // [R5] [R9]
      end
   end

   // Bit clock from master clock, channel clock from bit clock
   logic bclk_rise;
   logic bclk_fall;

   fac_edge_divider #(.RATIO_W(DIV_W)) u_bit_div (
      .clk        (ref_clk),
      .nrst       (nrst),
      .src_rise   (audio_master_clock_rise),
      .src_fall   (audio_master_clock_fall),
      .ratio      (bit_clock_divider),     // [R3]
      .phase_rise (bit_clock_phase),       // [R8]
      .div_out    (audio_bit_clock),
      .div_rise   (bclk_rise),
      .div_fall   (bclk_fall)
   );

   fac_edge_divider #(.RATIO_W(DIV_W)) u_chan_div (
      .clk        (ref_clk),
      .nrst       (nrst),
      .src_rise   (bclk_rise),
      .src_fall   (bclk_fall),
      .ratio      (channel_clock_divider), // [R4]
      .phase_rise (channel_clock_phase),   // [R7]
      .div_out    (channel_select_clock),
      .div_rise   (),
      .div_fall   ()
   );
endmodule : fac_audio_clock_gen

/* include/fac_pkg.sv */
// Constants for the field-locked audio clock generator: register subaddresses,
// field layouts, reset values and timing figures.
// Assumes a single 25 MHz reference clock drives every register of the block.
package fac_pkg;
   // Reference clock
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned CLK_PERIOD_NS   = 1_000_000_000 / CLK_HZ;

   // Field widths
   localparam int unsigned CPF_W           = 18;
   localparam int unsigned INC_W           = 22;
   localparam int unsigned DIV_W           = 6;
   localparam int unsigned CTRL_W          = 4;

   // Subaddresses
   localparam logic [7:0] ADDR_CPF_LOW     = 8'h30;
   localparam logic [7:0] ADDR_CPF_MID     = 8'h31;
   localparam logic [7:0] ADDR_CPF_HIGH    = 8'h32;
   localparam logic [7:0] ADDR_INC_LOW     = 8'h34;
   localparam logic [7:0] ADDR_INC_MID     = 8'h35;
   localparam logic [7:0] ADDR_INC_HIGH    = 8'h36;
   localparam logic [7:0] ADDR_BIT_RATIO   = 8'h38;
   localparam logic [7:0] ADDR_CHAN_RATIO  = 8'h39;
   localparam logic [7:0] ADDR_CTRL        = 8'h3a;

   // Implemented bits per byte register
   localparam logic [7:0] MASK_FULL        = 8'hff;
   localparam logic [7:0] MASK_CPF_HIGH    = 8'h03;
   localparam logic [7:0] MASK_INC_HIGH    = 8'h3f;
   localparam logic [7:0] MASK_RATIO       = 8'h3f;
   localparam logic [7:0] MASK_CTRL        = 8'h0f;
   localparam logic [7:0] MASK_NONE        = 8'h00;

   // Control register bit positions
   localparam int unsigned CTRL_PLL_OPEN   = 3;
   localparam int unsigned CTRL_VREF_SRC   = 2;
   localparam int unsigned CTRL_CHAN_PHASE = 1;
   localparam int unsigned CTRL_BIT_PHASE  = 0;

   // Reset values
   localparam logic [CPF_W-1:0]  RST_CPF   = 18'h0_0000;
   localparam logic [INC_W-1:0]  RST_INC   = 22'h00_0000;
   localparam logic [DIV_W-1:0]  RST_RATIO = 6'h00;
   localparam logic [CTRL_W-1:0] RST_CTRL  = 4'h0;

   // Phase accumulator and lock loop defaults
   localparam int unsigned ACC_W_DEF       = 24;
   localparam int unsigned LOOP_SHIFT_DEF  = 4;
endpackage : fac_pkg

/* core/fac_edge_divider.sv */
// Edge-counting clock divider with selectable trigger edge.
// Assumes source edges arrive as one-cycle pulses on the same clock.
`timescale 1ns/1ps
module fac_edge_divider #(
   parameter int unsigned RATIO_W = fac_pkg::DIV_W
) (
   input  wire logic               clk,        // Reference clock
   input  wire logic               nrst,       // Synchronous reset, active low
   input  wire logic               src_rise,   // Source clock rising edge pulse
   input  wire logic               src_fall,   // Source clock falling edge pulse
   input  wire logic [RATIO_W-1:0] ratio,      // Selected edges per half period
   input  wire logic               phase_rise, // 1: trigger on rising edges
   output logic                    div_out,    // Divided clock level
   output logic                    div_rise,   // Divided clock rising edge pulse
   output logic                    div_fall    // Divided clock falling edge pulse
);
   logic [RATIO_W-1:0] cnt;
   logic [RATIO_W-1:0] ratio_m1;
   logic               sel_edge;
   logic               last;
   logic               out_prev;

   // Ratio 0 behaves as ratio 1 so the output never stalls
   assign ratio_m1 = (ratio == '0) ? '0 : ratio - RATIO_W'(1);
   assign sel_edge = phase_rise ? src_rise : src_fall;
   // Compare with >= so a ratio lowered mid-count cannot run away
   assign last     = (cnt >= ratio_m1);

   always_ff @(posedge clk) begin
      if (!nrst) begin
         cnt     <= '0;
         div_out <= 1'b0;
      end else if (sel_edge) begin
         if (last) begin
            cnt     <= '0;
            div_out <= ~div_out;
         end else begin
            cnt <= cnt + RATIO_W'(1);
         end
      end
   end

   always_ff @(posedge clk) begin
      if (!nrst) begin
         out_prev <= 1'b0;
      end else begin
         out_prev <= div_out;
      end
   end

   assign div_rise = div_out & ~out_prev;
   assign div_fall = ~div_out & out_prev;
endmodule : fac_edge_divider

/* verif/fac_audio_clock_gen_checker.sv */
// Checker: port assertions for the audio clock generator, bound to its top.
// Assumes register writes are the only source of control and ratio changes.
`timescale 1ns/1ps
module fac_audio_clock_gen_checker (
   input  wire logic       ref_clk,              // Clock
   input  wire logic       nrst,                 // Reset, active low
   input  wire logic [7:0] reg_addr,             // Subaddress
   input  wire logic [7:0] reg_wdata,            // Write data
   input  wire logic       reg_wr,               // Write strobe
   input  wire logic       reg_rd,               // Read strobe
   input  wire logic [7:0] reg_rdata,            // Read data
   input  wire logic       audio_master_clock,   // Master clock
   input  wire logic       audio_bit_clock,      // Bit clock
   input  wire logic       channel_select_clock  // Channel clock
);
   logic [3:0] ctl;
   logic [5:0] brat;
   logic [5:0] age;
   logic [5:0] bcnt;
   logic [5:0] mh;
   logic [5:0] bh;
   logic       bok;
   wire        sel_edge = audio_master_clock != mh[0] && audio_master_clock == ctl[0];
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         ctl  <= 4'h0;
         brat <= 6'h00;
      end else if (reg_wr && reg_addr == 8'h3a) begin
         ctl <= reg_wdata[3:0];
      end else if (reg_wr && reg_addr == 8'h38) begin
         brat <= reg_wdata[5:0];
      end
   end
   // Pipelines may still carry old settings right after a write
   always_ff @(posedge ref_clk) begin
      if (!nrst || reg_wr) age <= 6'h00;
      else if (age != 6'h3f) age <= age + 6'h01;
   end
   always_ff @(posedge ref_clk) begin
      mh <= nrst ? {mh[4:0], audio_master_clock} : 6'h00;
      bh <= nrst ? {bh[4:0], audio_bit_clock} : 6'h00;
   end
   always_ff @(posedge ref_clk) begin
      if (!nrst || audio_bit_clock != bh[0]) bcnt <= 6'h00;
      else if (sel_edge) bcnt <= bcnt + 6'h01;
   end
   always_ff @(posedge ref_clk) begin
      if (!nrst || age != 6'h3f) bok <= 1'b0;
      else if (audio_bit_clock != bh[0]) bok <= 1'b1;
   end
   a_unmapped_reads_zero: assert property (
      reg_rd && !(reg_addr inside {[8'h30:8'h32], [8'h34:8'h36], [8'h38:8'h3a]})
      |=> reg_rdata == 8'h00) else $error("unmapped read not zero");
   a_count_top_bits: assert property (reg_rd && reg_addr == 8'h32 |=>
      reg_rdata[7:2] == 6'h00) else $error("count top byte upper bits set");
   a_incr_top_bits: assert property (reg_rd && reg_addr == 8'h36 |=>
      reg_rdata[7:6] == 2'h0) else $error("increment top byte upper bits set");
   a_ratio_upper_bits: assert property (reg_rd && reg_addr inside {8'h38, 8'h39}
      |=> reg_rdata[7:6] == 2'h0) else $error("ratio upper bits set");
   a_ctrl_upper_bits: assert property (reg_rd && reg_addr == 8'h3a |=>
      reg_rdata[7:4] == 4'h0) else $error("control upper bits set");
   a_write_read_back: assert property (reg_wr && reg_addr == 8'h31 ##1
      reg_rd && reg_addr == 8'h31 |=> reg_rdata == $past(reg_wdata, 2))
      else $error("count mid byte read back differs");
   a_bit_edge_phase: assert property ($changed(audio_bit_clock) && age == 6'h3f
      |-> audio_master_clock == ctl[0] && mh != {6{audio_master_clock}})
      else $error("bit clock moved on wrong master edge");
   a_chan_edge_phase: assert property ($changed(channel_select_clock) && age == 6'h3f
      |-> audio_bit_clock == ctl[1] && bh != {6{audio_bit_clock}})
      else $error("channel clock moved on wrong bit edge");
   a_bit_ratio_count: assert property ($changed(audio_bit_clock) && bok
      |-> bcnt == ((brat == 6'h00) ? 6'h01 : brat)) else $error("bit clock ratio wrong");
endmodule : fac_audio_clock_gen_checker
bind fac_audio_clock_gen fac_audio_clock_gen_checker i_chk (.ref_clk(ref_clk), .nrst(nrst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .audio_master_clock(audio_master_clock),
   .audio_bit_clock(audio_bit_clock), .channel_select_clock(channel_select_clock));

/* verif/fac_audio_sink.sv */
// Audio converter model: counts selected source edges per divided half period.
// Assumes its clock polarity settings are set to match the device.
`timescale 1ns/1ps
module fac_audio_sink (
   input  wire logic       ref_clk,        // Sampling clock
   input  wire logic       mclk,           // Master clock
   input  wire logic       bclk,           // Bit clock
   input  wire logic       lrclk,          // Channel clock
   input  wire logic       bit_pol,        // 1: bit clock follows master rise
   input  wire logic       chan_pol,       // 1: channel clock follows bit rise
   output logic      [7:0] bits_per_half,  // Master edges per bit half period
   output logic      [7:0] chans_per_half  // Bit edges per channel half period
);
   logic       mq = 1'b0, bq = 1'b0, lq = 1'b0;
   logic [7:0] mc = 8'h00, bc = 8'h00;
   always @(posedge ref_clk) begin
      mq <= mclk;
      bq <= bclk;
      lq <= lrclk;
      if (bclk != bq) begin
         bits_per_half <= mc;
         mc            <= 8'h00;
      end else if (mclk != mq && mclk == bit_pol) mc <= mc + 8'h01;
      if (lrclk != lq) begin
         chans_per_half <= bc;
         bc             <= 8'h00;
      end else if (bclk != bq && bclk == chan_pol) bc <= bc + 8'h01;
   end
endmodule : fac_audio_sink

/* verif/test_fac_audio_clock_gen.sv */
// Bench: register map, divider ratios and field lock of the audio clock generator.
// Assumes the checker is bound to the design; accumulator shortened to 8 bits.
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end
module test_fac_audio_clock_gen;
   logic       ref_clk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, bph, cph;
   logic       vref_internal = 1'b0, expansion_vertical_ref = 1'b0, bp = 1'b0, cp = 1'b0;
   logic       mclk, bclk, lrclk;
   int         error_cnt = 0, checks = 0, cyc = 0, ci = 0, ce = 0, per_int = 640;
   int         per_ext = 384, n;
   logic [7:0] ra [12] = '{8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37,
                          8'h38, 8'h39, 8'h3a, 8'h3b};
   logic [7:0] rm [12] = '{8'hff, 8'hff, 8'h03, 8'h00, 8'hff, 8'hff, 8'h3f, 8'h00,
                          8'h3f, 8'h3f, 8'h0f, 8'h00};
   logic [7:0] cb [4]  = '{8'h01, 8'h03, 8'h02, 8'h00};
   logic [7:0] cc [4]  = '{8'h01, 8'h02, 8'h05, 8'h04};
   fac_audio_clock_gen #(.ACC_W(8), .LOOP_SHIFT(2)) i_dut (.ref_clk(ref_clk), .nrst(nrst),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .vref_internal(vref_internal),
      .expansion_vertical_ref(expansion_vertical_ref), .audio_master_clock(mclk),
      .audio_bit_clock(bclk), .channel_select_clock(lrclk));
   fac_audio_sink i_sink (.ref_clk(ref_clk), .mclk(mclk), .bclk(bclk), .lrclk(lrclk),
      .bit_pol(bp), .chan_pol(cp), .bits_per_half(bph), .chans_per_half(cph));
   always #20 ref_clk = ~ref_clk;
   // Two field references at unrelated rates, so a wrong source shows
   always @(posedge ref_clk) begin
      #2;
      cyc = cyc + 1;
      ci <= (ci + 1) % per_int;
      ce <= (ce + 1) % per_ext;
      vref_internal <= ci == 0;
      expansion_vertical_ref <= ce < 8;
      if (cyc == 60000) begin
         error_cnt++;
         close_out();
      end
   end
   task automatic close_out();
      if (error_cnt == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out
   // Strobes stay up between calls so back-to-back access never double-drives
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      {reg_wr, reg_rd, reg_addr, reg_wdata} = {2'b10, a, d};
      @(posedge ref_clk) #2;
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      {reg_wr, reg_rd, reg_addr} = {2'b01, a};
      @(posedge ref_clk) #2;
      `CHK(reg_rdata, e)
   endtask : rdc
   task automatic idle(input int c);
      {reg_wr, reg_rd} = 2'b00;
      repeat (c) @(posedge ref_clk) #2;
   endtask : idle
   task automatic count_rises(output int k);
      logic q;
      k = 0;
      q = mclk;
      repeat (1280) begin
         @(posedge ref_clk) #2;
         if (mclk && !q) k++;
         q = mclk;
      end
   endtask : count_rises
   initial begin
      repeat (2) @(posedge ref_clk);
      #2 nrst = 1'b1;
      foreach (ra[i]) rdc(ra[i], 8'h00);
      foreach (ra[i]) begin
         wr(ra[i], 8'hff);
         rdc(ra[i], rm[i]);
         wr(ra[i], 8'h00);
      end
      // Master stopped while settings change, so no edge sees mixed settings
      for (int i = 0; i < 4; i++) begin
         wr(8'h34, 8'h00);
         idle(8);
         bp = i[0];
         cp = i[1];
         wr(8'h38, cb[i]);
         wr(8'h39, cc[i]);
         wr(8'h3a, {4'h0, 2'b10, cp, bp});
         wr(8'h34, 8'h08);
         idle(2600);
         `CHK(bph, (cb[i] == 8'h00) ? 8'h01 : cb[i])
         `CHK(cph, cc[i])
      end
      for (int s = 0; s < 2; s++) begin
         wr(8'h34, 8'h00);
         wr(8'h30, 8'h14);
         wr(8'h3a, s ? 8'h04 : 8'h00);
         per_int = s ? 384 : 640;
         per_ext = s ? 640 : 384;
         idle(10240);
         count_rises(n);
         `CHK(n inside {[37:43]}, 1'b1)
      end
      per_int = 640;
      wr(8'h34, 8'h08);
      wr(8'h30, 8'h3c);
      wr(8'h3a, 8'h08);
      idle(5120);
      count_rises(n);
      `CHK(n inside {[39:41]}, 1'b1)
      nrst = 1'b0;
      idle(2);
      nrst = 1'b1;
      rdc(8'h34, 8'h00);
      idle(1);
      close_out();
   end
endmodule : test_fac_audio_clock_gen
